// ===== verilog/hcd_core.sv
// harvard core datapath: four-phase fetch/execute pipeline, alu, working register, sfrs
`timescale 1ns/10ps
// Notes on behaviour
// - 8-bit alu adds, subtracts, shifts and does logic on w and file or literal.
// - arithmetic is two's complement unless an instruction says otherwise.
// - two-operand ops take w and either a file register or a literal.
// - single-operand ops work on w or a selected file register.
// - w is 8 bits, the accumulator, and has no data address.
// - carry, nibble and zero flags change only for instructions that affect them.
// - in subtraction carry and nibble flag mean no borrow.
// - each instruction is one 14-bit word fetched in one cycle.
// - fetch of next word overlaps execution; ops other than branches and taken skips take one cycle.
// - program and data memory use separate buses working concurrently.
// - special registers, program counter included, sit in data space.
// - in rc mode clock-out runs at a quarter of the input clock.
// - active-low master reset holds the device in reset while low.
// - input clock makes four phases; pc steps in phase one, fetch latched in four.
// - operand read in phase two, destination written in phase four.
// - pc-changing instructions take two cycles; the prefetched word is dropped.
module hcd_core (
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        rc_mode_i,
   input  wire logic [hcd_pkg::INSN_W-1:0]  prog_data_i,
   output logic      [hcd_pkg::PC_W-1:0]    prog_addr_o,
   output logic                             cycle_rate_out_o,
   output logic      [hcd_pkg::DATA_W-1:0]  w_o,
   output logic      [hcd_pkg::DATA_W-1:0]  status_o
);
   hcd_pkg::hcd_phase_type        phase_q, phase_d;
   logic [hcd_pkg::PC_W-1:0]      pc_q, pc_d, fetch_addr_q, fetch_addr_d;
   logic [hcd_pkg::INSN_W-1:0]    fetch_q, fetch_d, ir_q, ir_d;
   logic                          fetch_valid_q, fetch_valid_d, ir_valid_q, ir_valid_d;
   logic [hcd_pkg::DATA_W-1:0]    w_q, w_d, status_q, status_d, fsr_q, fsr_d;
   logic [hcd_pkg::LATCH_W-1:0]   pclath_q, pclath_d;
   logic                          clkout_q, clkout_d;

   logic [1:0]                    cls;
   logic [3:0]                    op4;
   logic [hcd_pkg::DATA_W-1:0]    lit, daddr, file_val, a_opnd, b_opnd, res, mask;
   logic [hcd_pkg::FADDR_W-1:0]   fa;
   logic [8:0]                    sum9;
   logic [4:0]                    nib5;
   logic                          exec, is_sub, is_add, is_sfr, upd_z, upd_c, upd_dc;
   logic                          c_new, wr_file, wr_w, skip, jump, take_branch, w_load;
   logic [hcd_pkg::PC_W-1:0]      target;

   hcd_mem_if mem_if ();

   hcd_regfile u_regfile (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .bus       (mem_if.mem)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode and operand selection
   assign cls   = ir_q[13:12];
   assign op4   = ir_q[11:8];
   assign lit   = ir_q[7:0];
   assign exec  = ir_valid_q && (phase_q == hcd_pkg::phase_four);
   // indirect slot goes through fsr; bank bit extends direct address
   assign daddr = (ir_q[6:0] == hcd_pkg::ADR_INDIRECT) ? fsr_q : {status_q[hcd_pkg::ST_BANK], ir_q[6:0]};
   assign fa    = daddr[hcd_pkg::FADDR_W-1:0];
   assign is_sub = ((cls == hcd_pkg::CLS_BYTE) || (cls == hcd_pkg::CLS_LIT)) && (op4 == hcd_pkg::OP_SUB);
   assign is_add = ((cls == hcd_pkg::CLS_BYTE) || (cls == hcd_pkg::CLS_LIT)) && (op4 == hcd_pkg::OP_ADD);

   // special registers answer from the core, the rest from the file
   always_comb begin
      is_sfr = 1'b1;
      unique case (fa)
         hcd_pkg::ADR_INDIRECT: file_val = hcd_pkg::BYTE_0;
         hcd_pkg::ADR_PCL:      file_val = pc_q[hcd_pkg::DATA_W-1:0];
         hcd_pkg::ADR_STATUS:   file_val = status_q;
         hcd_pkg::ADR_FSR:      file_val = fsr_q;
         hcd_pkg::ADR_PCLATH:   file_val = {3'b000, pclath_q};
         default: begin
            is_sfr   = 1'b0;
            file_val = mem_if.rdata;
         end
      endcase
   end

   // data bus works beside the program bus in the same cycle
   assign mem_if.addr  = fa;
   assign mem_if.rd_en = ir_valid_q && (phase_q == hcd_pkg::phase_two) && !cls[1];
   assign mem_if.wr_en = exec && wr_file && !is_sfr;
   assign mem_if.wdata = res;

   ////////////////////////////////////////////////////////////////////////////
   // alu
   always_comb begin
      a_opnd = (cls == hcd_pkg::CLS_LIT) ? lit : file_val;
      b_opnd = is_sub ? ~w_q : w_q;
      sum9   = {1'b0, a_opnd} + {1'b0, b_opnd} + {8'h00, is_sub};
      nib5   = {1'b0, a_opnd[3:0]} + {1'b0, b_opnd[3:0]} + {4'h0, is_sub};
      mask   = hcd_pkg::DATA_W'(hcd_pkg::BYTE_1 << ir_q[9:7]);
      res    = a_opnd;
      upd_z  = 1'b0;
      upd_c  = 1'b0;
      upd_dc = 1'b0;
      c_new  = sum9[8];
      wr_file = 1'b0;
      wr_w   = 1'b0;
      skip   = 1'b0;
      jump   = 1'b0;
      unique case (cls)
         hcd_pkg::CLS_BYTE: begin
            wr_file = ir_q[7];
            wr_w    = !ir_q[7];
            unique case (op4)
               hcd_pkg::OP_MOVW: begin
                  res  = w_q;
                  wr_w = 1'b0;
               end
               hcd_pkg::OP_CLR: begin
                  res   = hcd_pkg::BYTE_0;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_SUB, hcd_pkg::OP_ADD: begin
                  res    = sum9[7:0];
                  upd_z  = 1'b1;
                  upd_c  = 1'b1;
                  upd_dc = 1'b1;
               end
               hcd_pkg::OP_DEC: begin
                  res   = a_opnd - hcd_pkg::BYTE_1;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_IOR: begin
                  res   = a_opnd | w_q;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_AND: begin
                  res   = a_opnd & w_q;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_XOR: begin
                  res   = a_opnd ^ w_q;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_MOV:  upd_z = 1'b1;
               hcd_pkg::OP_COM: begin
                  res   = ~a_opnd;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_INC: begin
                  res   = a_opnd + hcd_pkg::BYTE_1;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_DECS: begin
                  res  = a_opnd - hcd_pkg::BYTE_1;
                  skip = (res == hcd_pkg::BYTE_0);
               end
               hcd_pkg::OP_INCS: begin
                  res  = a_opnd + hcd_pkg::BYTE_1;
                  skip = (res == hcd_pkg::BYTE_0);
               end
               hcd_pkg::OP_RRC: begin
                  res   = {status_q[hcd_pkg::ST_CARRY], a_opnd[7:1]};
                  upd_c = 1'b1;
                  c_new = a_opnd[0];
               end
               hcd_pkg::OP_RLC: begin
                  res   = {a_opnd[6:0], status_q[hcd_pkg::ST_CARRY]};
                  upd_c = 1'b1;
                  c_new = a_opnd[7];
               end
               hcd_pkg::OP_SWAP: res = {a_opnd[3:0], a_opnd[7:4]};
            endcase
         end
         hcd_pkg::CLS_BIT: begin
            unique case (ir_q[11:10])
               hcd_pkg::BOP_CLR: begin
                  res     = a_opnd & ~mask;
                  wr_file = 1'b1;
               end
               hcd_pkg::BOP_SET: begin
                  res     = a_opnd | mask;
                  wr_file = 1'b1;
               end
               hcd_pkg::BOP_SKIP0: skip = ((a_opnd & mask) == hcd_pkg::BYTE_0);
               hcd_pkg::BOP_SKIP1: skip = ((a_opnd & mask) != hcd_pkg::BYTE_0);
            endcase
         end
         hcd_pkg::CLS_JUMP: jump = 1'b1;
         hcd_pkg::CLS_LIT: begin
            wr_w = 1'b1;
            unique case (op4)
               hcd_pkg::OP_SUB, hcd_pkg::OP_ADD: begin
                  res    = sum9[7:0];
                  upd_z  = 1'b1;
                  upd_c  = 1'b1;
                  upd_dc = 1'b1;
               end
               hcd_pkg::OP_IOR: begin
                  res   = lit | w_q;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_AND: begin
                  res   = lit & w_q;
                  upd_z = 1'b1;
               end
               hcd_pkg::OP_XOR: begin
                  res   = lit ^ w_q;
                  upd_z = 1'b1;
               end
               default: upd_z = 1'b0;
            endcase
         end
      endcase
   end

   // writing pcl is a jump as well
   assign take_branch = jump || (wr_file && (fa == hcd_pkg::ADR_PCL));
   assign target = jump ? {pclath_q[4:3], ir_q[hcd_pkg::JUMP_W-1:0]} : {pclath_q, res};
   assign w_load = exec && wr_w;

   ////////////////////////////////////////////////////////////////////////////
   // sequencing and architectural state
   always_comb begin
      phase_d       = phase_q;
      pc_d          = pc_q;
      fetch_addr_d  = fetch_addr_q;
      fetch_d       = fetch_q;
      fetch_valid_d = fetch_valid_q;
      ir_d          = ir_q;
      ir_valid_d    = ir_valid_q;
      w_d           = w_load ? res : w_q;
      fsr_d         = (exec && wr_file && (fa == hcd_pkg::ADR_FSR)) ? res : fsr_q;
      pclath_d      = (exec && wr_file && (fa == hcd_pkg::ADR_PCLATH)) ? res[4:0] : pclath_q;
      status_d      = (exec && wr_file && (fa == hcd_pkg::ADR_STATUS)) ? res : status_q;
      if (exec && upd_z) status_d[hcd_pkg::ST_ZERO] = (res == hcd_pkg::BYTE_0);
      if (exec && upd_c) status_d[hcd_pkg::ST_CARRY] = c_new;
      if (exec && upd_dc) status_d[hcd_pkg::ST_NIBBLE] = nib5[4];
      // clock-out high in phases three and four
      clkout_d = rc_mode_i && ((phase_q == hcd_pkg::phase_two) || (phase_q == hcd_pkg::phase_three));
      unique case (phase_q)
         hcd_pkg::phase_one: begin
            phase_d      = hcd_pkg::phase_two;
            fetch_addr_d = pc_q;
            pc_d         = pc_q + hcd_pkg::PC_ONE;
            ir_d         = fetch_q;
            ir_valid_d   = fetch_valid_q;
         end
         hcd_pkg::phase_two:   phase_d = hcd_pkg::phase_three;
         hcd_pkg::phase_three: phase_d = hcd_pkg::phase_four;
         hcd_pkg::phase_four: begin
            phase_d       = hcd_pkg::phase_one;
            fetch_d       = prog_data_i;
            fetch_valid_d = !(exec && (take_branch || skip));
            if (exec && take_branch) pc_d = target;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_q       <= hcd_pkg::phase_one;
         pc_q          <= hcd_pkg::PC_RESET;
         fetch_addr_q  <= hcd_pkg::PC_RESET;
         fetch_q       <= hcd_pkg::INSN_0;
         fetch_valid_q <= 1'b0;
         ir_q          <= hcd_pkg::INSN_0;
         ir_valid_q    <= 1'b0;
         w_q           <= hcd_pkg::BYTE_0;
         status_q      <= hcd_pkg::BYTE_0;
         fsr_q         <= hcd_pkg::BYTE_0;
         pclath_q      <= hcd_pkg::LATCH_0;
         clkout_q      <= 1'b0;
      end else begin
         phase_q       <= phase_d;
         pc_q          <= pc_d;
         fetch_addr_q  <= fetch_addr_d;
         fetch_q       <= fetch_d;
         fetch_valid_q <= fetch_valid_d;
         ir_q          <= ir_d;
         ir_valid_q    <= ir_valid_d;
         w_q           <= w_d;
         status_q      <= status_d;
         fsr_q         <= fsr_d;
         pclath_q      <= pclath_d;
         clkout_q      <= clkout_d;
      end
   end

   assign prog_addr_o      = fetch_addr_q;
   assign cycle_rate_out_o = clkout_q;
   assign w_o              = w_q;
   assign status_o         = status_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_pc_step;
      (phase_q == hcd_pkg::phase_one) |=> (pc_q == $past(pc_q) + hcd_pkg::PC_ONE) ##3 (phase_q == hcd_pkg::phase_one);
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step in phase one");

   property p_fetch_latch;
      (phase_q == hcd_pkg::phase_four) |=> (fetch_q == $past(prog_data_i));
   endproperty
   a_fetch_latch: assert property (p_fetch_latch) else $error("fetch word not latched");

   property p_read_phase;
      mem_if.rd_en |-> (phase_q == hcd_pkg::phase_two) ##2 (phase_q == hcd_pkg::phase_four);
   endproperty
   a_read_phase: assert property (p_read_phase) else $error("operand read outside phase two");

   property p_write_phase;
      mem_if.wr_en |-> exec;
   endproperty
   a_write_phase: assert property (p_write_phase) else $error("file write outside phase four");

   property p_flush;
      (exec && (take_branch || skip)) |-> ##2 !ir_valid_q;
   endproperty
   a_flush: assert property (p_flush) else $error("prefetched word not dropped");

   property p_zero;
      (exec && upd_z) |=> (status_q[hcd_pkg::ST_ZERO] == ($past(res) == hcd_pkg::BYTE_0));
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_borrow;
      (exec && is_sub) |=> (status_q[hcd_pkg::ST_CARRY] == ($past(a_opnd) >= $past(w_q)));
   endproperty
   a_borrow: assert property (p_borrow) else $error("borrow flag wrong");

   property p_nibble;
      (exec && is_add) |=> (status_q[hcd_pkg::ST_NIBBLE] ==
         (({1'b0, $past(a_opnd[3:0])} + {1'b0, $past(w_q[3:0])}) >= hcd_pkg::NIB_OVF));
   endproperty
   a_nibble: assert property (p_nibble) else $error("nibble flag wrong");

   property p_w_load;
      !$stable(w_q) |-> $past(w_load);
   endproperty
   a_w_load: assert property (p_w_load) else $error("w changed without a load");

   property p_flags_hold;
      (phase_q != hcd_pkg::phase_four) |=> $stable(status_q);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("status changed outside execute");

   property p_clkout;
      (rc_mode_i && (phase_q == hcd_pkg::phase_two)) ##1 rc_mode_i |=>
         cycle_rate_out_o ##1 !cycle_rate_out_o ##1 !cycle_rate_out_o;
   endproperty
   a_clkout: assert property (p_clkout) else $error("clock-out not a quarter rate");

   c_branch: cover property (exec && jump);
   c_skip: cover property (exec && skip);
   c_borrow: cover property (exec && is_sub && !c_new);
   c_indirect: cover property (exec && (ir_q[6:0] == hcd_pkg::ADR_INDIRECT) && !cls[1]);
endmodule : hcd_core

// ===== verilog/hcd_pkg.sv
// package: constants and types shared by the harvard core datapath files
package hcd_pkg;
   localparam int DATA_W    = 8;
   localparam int INSN_W    = 14;
   localparam int PC_W      = 13;
   localparam int LATCH_W   = 5;
   localparam int FADDR_W   = 7;
   localparam int MEM_DEPTH = 128;
   localparam int JUMP_W    = 11;

   localparam logic [PC_W-1:0]    PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0]    PC_ONE   = 13'h0001;
   localparam logic [DATA_W-1:0]  BYTE_0   = 8'h00;
   localparam logic [DATA_W-1:0]  BYTE_1   = 8'h01;
   localparam logic [LATCH_W-1:0] LATCH_0  = 5'h00;
   localparam logic [INSN_W-1:0]  INSN_0   = 14'h0000;
   localparam logic [4:0]         NIB_OVF  = 5'h10;

   // special function register addresses, mirrored in both banks
   localparam logic [FADDR_W-1:0] ADR_INDIRECT = 7'h00;
   localparam logic [FADDR_W-1:0] ADR_PCL      = 7'h02;
   localparam logic [FADDR_W-1:0] ADR_STATUS   = 7'h03;
   localparam logic [FADDR_W-1:0] ADR_FSR      = 7'h04;
   localparam logic [FADDR_W-1:0] ADR_PCLATH   = 7'h0a;

   // status bit positions
   localparam int ST_CARRY  = 0;
   localparam int ST_NIBBLE = 1;
   localparam int ST_ZERO   = 2;
   localparam int ST_BANK   = 5;

   // instruction classes in word bits 13:12
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT  = 2'h1;
   localparam logic [1:0] CLS_JUMP = 2'h2;
   localparam logic [1:0] CLS_LIT  = 2'h3;

   // byte-oriented operations in word bits 11:8
   localparam logic [3:0] OP_MOVW = 4'h0;
   localparam logic [3:0] OP_CLR  = 4'h1;
   localparam logic [3:0] OP_SUB  = 4'h2;
   localparam logic [3:0] OP_DEC  = 4'h3;
   localparam logic [3:0] OP_IOR  = 4'h4;
   localparam logic [3:0] OP_AND  = 4'h5;
   localparam logic [3:0] OP_XOR  = 4'h6;
   localparam logic [3:0] OP_ADD  = 4'h7;
   localparam logic [3:0] OP_MOV  = 4'h8;
   localparam logic [3:0] OP_COM  = 4'h9;
   localparam logic [3:0] OP_INC  = 4'ha;
   localparam logic [3:0] OP_DECS = 4'hb;
   localparam logic [3:0] OP_RRC  = 4'hc;
   localparam logic [3:0] OP_RLC  = 4'hd;
   localparam logic [3:0] OP_SWAP = 4'he;
   localparam logic [3:0] OP_INCS = 4'hf;

   // bit operations in word bits 11:10
   localparam logic [1:0] BOP_CLR   = 2'h0;
   localparam logic [1:0] BOP_SET   = 2'h1;
   localparam logic [1:0] BOP_SKIP0 = 2'h2;
   localparam logic [1:0] BOP_SKIP1 = 2'h3;

   typedef enum logic [1:0] {phase_one, phase_two, phase_three, phase_four} hcd_phase_type;
endpackage : hcd_pkg

// ===== verilog/hcd_mem_if.sv
// interface: core to data register file connection
`timescale 1ns/10ps
interface hcd_mem_if;
   logic [hcd_pkg::FADDR_W-1:0] addr;
   logic                        rd_en;
   logic                        wr_en;
   logic [hcd_pkg::DATA_W-1:0]  wdata;
   logic [hcd_pkg::DATA_W-1:0]  rdata;

   modport core (output addr, output rd_en, output wr_en, output wdata, input rdata);
   modport mem  (input addr, input rd_en, input wr_en, input wdata, output rdata);
endinterface : hcd_mem_if

// ===== verilog/hcd_regfile.sv
// general purpose data register file with registered read data
`timescale 1ns/10ps
module hcd_regfile (
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   hcd_mem_if.mem    bus
);
   logic [hcd_pkg::DATA_W-1:0] mem_q [hcd_pkg::MEM_DEPTH];
   logic [hcd_pkg::DATA_W-1:0] rdata_q;
   logic [hcd_pkg::DATA_W-1:0] rdata_d;

   always_comb begin
      rdata_d = bus.rd_en ? mem_q[bus.addr] : rdata_q;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= hcd_pkg::BYTE_0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // storage has no reset, like static ram
   always_ff @(posedge sys_clk_i) begin
      if (bus.wr_en) begin
         mem_q[bus.addr] <= bus.wdata;
      end
   end

   assign bus.rdata = rdata_q;
endmodule : hcd_regfile

// ===== sim/hcd_prog_rom.sv
// partner model: program memory on its own fetch bus, combinational word read
`timescale 1ns/10ps
module hcd_prog_rom (
   input  wire logic [hcd_pkg::PC_W-1:0]   addr_i,
   output logic      [hcd_pkg::INSN_W-1:0] data_o
);
   logic [hcd_pkg::INSN_W-1:0] mem [64];

   // separate bus, whole word ready for every fetch address
   always_comb begin
      if (addr_i < 13'h0040) begin
         data_o = mem[addr_i[5:0]];
      end else begin
         data_o = 14'h3fff;
      end
   end
endmodule : hcd_prog_rom

// ===== sim/test_harvard_core_alu_datapath.sv
// testbench: pipeline, alu, file register, branch and reset scenarios for the core
`timescale 1ns/10ps
module test_harvard_core_alu_datapath;
   logic                            sys_clk_i        = 1'b0;
   logic                            rst_n_i          = 1'b0;
   logic                            rc_mode_i        = 1'b1;
   wire logic [hcd_pkg::INSN_W-1:0] prog_data_i;
   logic      [hcd_pkg::PC_W-1:0]   prog_addr_o;
   logic                            cycle_rate_out_o;
   logic      [hcd_pkg::DATA_W-1:0] w_o;
   logic      [hcd_pkg::DATA_W-1:0] status_o;
   int                              cyc              = 0;
   int                              bad_count        = 0;
   int                              comparisons      = 0;
   logic      [13:0]                alu_prog [$]     = '{14'h300f, 14'h3701, 14'h37f0, 14'h3005, 14'h3203,
                                                         14'h32ff, 14'h35f0, 14'h345a, 14'h36ff};

   always #2.5 sys_clk_i = ~sys_clk_i;

   // edges counted from reset release
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) cyc <= 0;
      else cyc <= cyc + 1;
   end

   hcd_core DUT (.sys_clk_i (sys_clk_i), .rst_n_i (rst_n_i), .rc_mode_i (rc_mode_i),
                 .prog_data_i (prog_data_i), .prog_addr_o (prog_addr_o),
                 .cycle_rate_out_o (cycle_rate_out_o), .w_o (w_o), .status_o (status_o));
   hcd_prog_rom u_rom (.addr_i (prog_addr_o), .data_o (prog_data_i));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic at_cyc(input int n);
      while (cyc != n) @(negedge sys_clk_i);
   endtask : at_cyc

   task automatic start(input logic [13:0] prog [$]);
      int i;
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      for (i = 0; i < 64; i++) u_rom.mem[i] = (i < prog.size()) ? prog[i] : 14'h3000;
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
   endtask : start

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_pipe;
      int n;
      start(alu_prog);
      for (n = 1; n <= 12; n++) begin
         at_cyc(n);
         check(16'(prog_addr_o), 16'((n - 1) / 4));
         check(16'(cycle_rate_out_o), 16'(n % 4 >= 2));
      end
      @(posedge sys_clk_i);
      rc_mode_i <= 1'b0;
      for (n = 15; n <= 22; n++) begin
         at_cyc(n);
         check(16'(cycle_rate_out_o), 16'h0000);
      end
      @(posedge sys_clk_i);
      rc_mode_i <= 1'b1;
   endtask : t_pipe

   task automatic t_alu;
      logic [7:0] ew [9] = '{8'h0f, 8'h10, 8'h00, 8'h05, 8'hfe, 8'h01, 8'h00, 8'h5a, 8'ha5};
      logic [7:0] es [9] = '{8'h00, 8'h02, 8'h05, 8'h05, 8'h00, 8'h03, 8'h07, 8'h03, 8'h03};
      logic [7:0] prev;
      int         i;
      start(alu_prog);
      prev = 8'h00;
      for (i = 0; i < 9; i++) begin
         at_cyc(4 * i + 7);
         check(16'(w_o), 16'(prev));
         at_cyc(4 * i + 8);
         check(16'(w_o), 16'(ew[i]));
         check(16'(status_o), 16'(es[i]));
         prev = ew[i];
      end
   endtask : t_alu

   task automatic t_file;
      int         ix [5] = '{3, 4, 5, 8, 9};
      logic [7:0] ew [5] = '{8'h3d, 8'hc3, 8'h78, 8'h00, 8'h01};
      logic [7:0] es [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
      int         i;
      start('{14'h303c, 14'h00a0, 14'h3001, 14'h0720, 14'h0920, 14'h0d20, 14'h3080, 14'h00a0,
              14'h0d20, 14'h0803});
      for (i = 0; i < 5; i++) begin
         at_cyc(4 * ix[i] + 8);
         check(16'(w_o), 16'(ew[i]));
         check(16'(status_o), 16'(es[i]));
      end
   endtask : t_file

   task automatic t_branch;
      start('{14'h3011, 14'h2003, 14'h3022, 14'h3701});
      at_cyc(8);
      check(16'(w_o), 16'h0011);
      at_cyc(13);
      check(16'(prog_addr_o), 16'h0003);
      at_cyc(16);
      check(16'(w_o), 16'h0011);
      at_cyc(20);
      check(16'(w_o), 16'h0012);
   endtask : t_branch

   // fsr write, indirect store and load, then a taken bit-test skip
   task automatic t_skip_ind;
      start('{14'h3025, 14'h0084, 14'h0080, 14'h3000, 14'h0800, 14'h1903, 14'h3077, 14'h3701});
      at_cyc(24);
      check(16'(w_o), 16'h0025);
      at_cyc(32);
      check(16'(w_o), 16'h0025);
      at_cyc(36);
      check(16'(w_o), 16'h0026);
      check(16'(status_o), 16'h0000);
   endtask : t_skip_ind

   task automatic t_reset_mid;
      int k;
      start(alu_prog);
      at_cyc(14);
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      for (k = 0; k < 4; k++) begin
         @(negedge sys_clk_i);
         check({prog_addr_o, 3'h0}, 16'h0000);
         check({w_o, status_o}, 16'h0000);
         check(16'(cycle_rate_out_o), 16'h0000);
      end
      @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      at_cyc(8);
      check(16'(w_o), 16'h000f);
   endtask : t_reset_mid

   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (20) @(posedge sys_clk_i);
      t_pipe();
      t_alu();
      t_file();
      t_branch();
      t_skip_ind();
      t_reset_mid();
      report_and_stop();
   end

   // watchdog, well past the few hundred cycles the scenarios need
   initial begin
      #20000;
      bad_count++;
      report_and_stop();
   end
endmodule : test_harvard_core_alu_datapath
